/* core/cfs_pkg.sv */
package cfs_pkg;
  // ==========================================================
  // Condition-code layout
  localparam int CCR_W = 6;
  localparam int F_H   = 5;
  localparam int F_I   = 4;
  localparam int F_N   = 3;
  localparam int F_Z   = 2;
  localparam int F_V   = 1;
  localparam int F_C   = 0;
  localparam logic [CCR_W-1:0] CCR_RST = 6'h10;

  // ==========================================================
  // Opcodes and operand tests
  localparam logic [7:0] OP_TAP  = 8'h06;
  localparam logic [7:0] OP_CLI  = 8'h0E;
  localparam logic [7:0] OP_SEI  = 8'h0F;
  localparam logic [7:0] OP_DAA  = 8'h19;
  localparam logic [7:0] OP_RTI  = 8'h3B;
  localparam logic [7:0] OP_MUL  = 8'h3D;
  localparam logic [7:0] OP_WAI  = 8'h3E;
  localparam logic [7:0] OP_LSRD = 8'h04;
  localparam logic [7:0] OP_ASLD = 8'h05;
  localparam logic [7:0] VAL_80  = 8'h80;
  localparam logic [7:0] VAL_7F  = 8'h7F;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] LO_NEG  = 4'h0;
  localparam logic [3:0] LO_DEC  = 4'hA;
  localparam logic [3:0] LO_INC  = 4'hC;
  localparam logic [3:0] LO_D16  = 4'h3;
  localparam logic [3:0] LO_LDD  = 4'hC;
  localparam logic [3:0] HI_RMW0 = 4'h4;
  localparam logic [3:0] HI_RMW3 = 4'h7;
  localparam logic [3:0] HI_ACCUMULATOR_B = 4'hC;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_UNDEF  = 4'h8;
  localparam int CTRL_IRQ_EN  = 0;
  localparam int CTRL_TRAP_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int ST_WAIT_B = 8;
  localparam int ST_BUSY_B = 9;
  localparam int ST_ARM_B  = 10;
  localparam int UND_OP_LSB = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] ADDR_ONES  = 16'hFFFF;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_WAIT = 3'h4
  } cfs_state_t;

  typedef struct packed {
    logic [7:0]       opcode;
    logic [2:0]       cycles;
    logic [15:0]      result;
    logic [7:0]       operand;
    logic [7:0]       acc_a;
    logic [CCR_W-1:0] stacked;
    logic [CCR_W-1:0] alu_flags;
    logic [CCR_W-1:0] alu_mask;
  } cfs_exec_t;

  // Holes in the opcode map; 61/62/65/6B/71/72/75/7B are the
  // immediate-to-memory group and stay defined
  function automatic logic cfs_undef(input logic [7:0] op);
    logic u;
    u = 1'b0;
    unique case (op)
      8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15,
      8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h41, 8'h42, 8'h45,
      8'h4B, 8'h4E, 8'h51, 8'h52, 8'h55, 8'h5B, 8'h5E,
      8'h87, 8'h8F, 8'hC7, 8'hCD, 8'hCF: u = 1'b1;
      default: u = 1'b0;
    endcase
    return u;
  endfunction
endpackage

/* core/cfs_flag_seq.sv */
`timescale 1ns/1ps
// Operation
// - Overflow set when the 8-bit result is 80 hex, else cleared.
// - Decimal adjust sets carry if high digit above nine; never clears it.
// - Overflow set when operand was 80 hex before execution, else cleared.
// - Overflow set when operand was 7F hex before execution, else cleared.
// - Shifts and rotates take overflow from negative combined with carry.
// - Sixteen-bit results take negative from result bit 15.
// - Return from interrupt reloads every flag from the stacked value.
// - Wait sets mask on interrupt; masked entry exits only on NMI.
// - Accumulator-to-flags transfer loads all flags from accumulator A.
// - Multiply sets carry from bit 7 of the low product byte.
// - Mask clear then one-cycle instruction: two more run before service.
// - Mask clear then longer instruction: only it runs, then vector.
// - Transfer clearing the mask delays interrupts like clear-mask.
// - Next opcode is fetched during the last cycle of the current one.
// - Only immediate-to-memory ops use reserved slots; other holes undefined.
// - In wait: halt indicator high, address all ones, data bus released.
module cfs_flag_seq
  import cfs_pkg::*;
#(
  parameter int AW = 4
)(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             exec_valid,
  output logic                  exec_ready,
  input  wire cfs_exec_t        exec_in,
  output logic                  instr_end,
  output logic                  fetch_next,
  output logic                  undef_opcode,
  input  wire logic             maskable_request_one_n,
  input  wire logic             maskable_request_two_n,
  input  wire logic             nmi_n,
  output logic                  irq_take,
  output logic                  nmi_take,
  output logic [CCR_W-1:0]      ccr,
  output logic                  halt_wait,
  output logic [15:0]           addr_force,
  output logic                  data_bus_oe,
  input  wire logic [AW-1:0]    s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [AW-1:0]    s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // ==========================================================
  // Sequencer state
  cfs_state_t       st_q, st_d;
  logic [2:0]       cnt_q, cnt_d;
  cfs_exec_t        cur_q, cur_d;
  logic [CCR_W-1:0] ccr_q, ccr_d, flg;
  logic             arm_q, arm_d;
  logic             wmask_q, wmask_d;
  logic [1:0]       ctrl_q, ctrl_d;
  logic             und_q, und_d;
  logic [7:0]       und_op_q, und_op_d;
  logic             bvalid_q, bvalid_d;
  logic [1:0]       bresp_q, bresp_d;
  logic             rvalid_q, rvalid_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [1:0]       rresp_q, rresp_d;
  logic             accept, irq_req, one_cyc, w_hs, r_hs, und_evt;
  logic [3:0]       hi, lo;

  assign irq_req = (!maskable_request_one_n || !maskable_request_two_n)
                   && ctrl_q[CTRL_IRQ_EN];
  assign exec_ready = (st_q == ST_IDLE);
  assign accept     = exec_valid && exec_ready;
  assign instr_end  = (st_q == ST_EXEC) && (cnt_q <= 3'h1);
  assign fetch_next = instr_end;
  assign one_cyc    = (cur_q.cycles <= 3'h1);
  assign hi = cur_q.opcode[7:4];
  assign lo = cur_q.opcode[3:0];
  assign und_evt = accept && cfs_undef(exec_in.opcode);
  assign undef_opcode = und_evt && ctrl_q[CTRL_TRAP_EN];

  // Flag update for the ending instruction
  always_comb
  begin
    flg = (ccr_q & ~cur_q.alu_mask) | (cur_q.alu_flags & cur_q.alu_mask);
    if ((hi >= HI_RMW0) && (hi <= HI_RMW3))
    begin
      unique case (lo)
        LO_NEG: flg[F_V] = (cur_q.result[7:0] == VAL_80);
        LO_DEC: flg[F_V] = (cur_q.operand == VAL_80);
        LO_INC: flg[F_V] = (cur_q.operand == VAL_7F);
        4'h4, 4'h6, 4'h7, 4'h8, 4'h9:
          flg[F_V] = flg[F_N] ^ flg[F_C];
        default: ;
      endcase
    end
    // Overflow must see the negative flag of this result, so N goes first
    if (cur_q.opcode == OP_LSRD || cur_q.opcode == OP_ASLD)
    begin
      flg[F_N] = cur_q.result[15];
      flg[F_V] = flg[F_N] ^ flg[F_C];
    end
    if ((cur_q.opcode[7] && lo == LO_D16) ||
        (hi >= HI_ACCUMULATOR_B && lo == LO_LDD))
      flg[F_N] = cur_q.result[15];
    unique case (cur_q.opcode)
      OP_DAA: flg[F_C] = ccr_q[F_C] || (cur_q.operand[7:4] > BCD_MAX);
      OP_MUL: flg[F_C] = cur_q.result[7];
      OP_RTI: flg = cur_q.stacked;
      OP_TAP: flg = cur_q.acc_a[CCR_W-1:0];
      OP_CLI: flg[F_I] = 1'b0;
      OP_SEI: flg[F_I] = 1'b1;
      default: ;
    endcase
  end

  // ==========================================================
  // Instruction and interrupt sequencing
  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    cur_d    = cur_q;
    ccr_d    = ccr_q;
    arm_d    = arm_q;
    wmask_d  = wmask_q;
    irq_take = 1'b0;
    nmi_take = 1'b0;
    unique case (st_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          cur_d = exec_in;
          cnt_d = exec_in.cycles;
          st_d  = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        cnt_d = cnt_q - 3'h1;
        if (instr_end)
        begin
          ccr_d = flg;
          st_d  = ST_IDLE;
          // Mask clear defers service by one or two instructions
          arm_d = ccr_q[F_I] && !flg[F_I];
          // Blocked only when the deferred one is single-cycle
          if (!ccr_q[F_I] && irq_req && !(arm_q && one_cyc))
          begin
            irq_take   = 1'b1;
            ccr_d[F_I] = 1'b1;
            arm_d      = 1'b0;
          end
          else if (cur_q.opcode == OP_WAI)
          begin
            st_d    = ST_WAIT;
            wmask_d = ccr_q[F_I];
          end
        end
      end
      ST_WAIT:
      begin
        if (!nmi_n || (!wmask_q && irq_req))
        begin
          nmi_take   = !nmi_n;
          irq_take   = nmi_n;
          ccr_d[F_I] = 1'b1;
          st_d       = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q    <= ST_IDLE;
      cnt_q   <= 3'h0;
      cur_q   <= '0;
      ccr_q   <= CCR_RST;
      arm_q   <= 1'b0;
      wmask_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      cur_q   <= cur_d;
      ccr_q   <= ccr_d;
      arm_q   <= arm_d;
      wmask_q <= wmask_d;
    end
  end

  assign ccr         = ccr_q;
  assign halt_wait   = (st_q == ST_WAIT);
  assign addr_force  = halt_wait ? ADDR_ONES : 16'h0000;
  // Outside wait the bus owner decides; we only release it here
  assign data_bus_oe = !halt_wait;

  // ==========================================================
  // AXI4-Lite slave
  // Address and data are taken together; a master that offers
  // them apart just waits for the second one
  assign w_hs = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign r_hs = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = w_hs;
  assign s_axi_wready  = w_hs;
  assign s_axi_arready = r_hs;

  always_comb
  begin
    ctrl_d   = ctrl_q;
    und_d    = und_q;
    und_op_d = und_op_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (w_hs)
    begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      unique case (s_axi_awaddr)
        ADDR_CTRL:
          if (s_axi_wstrb[0])
            ctrl_d = s_axi_wdata[1:0];
        ADDR_UNDEF:
          if (s_axi_wstrb[0] && s_axi_wdata[0])
            und_d = 1'b0;
        ADDR_STATUS: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    // Set after clear so a new event is never lost
    if (und_evt)
    begin
      und_d    = 1'b1;
      und_op_d = exec_in.opcode;
    end
    if (r_hs)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_d[1:0] = ctrl_q;
        ADDR_STATUS:
        begin
          rdata_d[CCR_W-1:0] = ccr_q;
          rdata_d[ST_WAIT_B] = halt_wait;
          rdata_d[ST_BUSY_B] = (st_q == ST_EXEC);
          rdata_d[ST_ARM_B]  = arm_q;
        end
        ADDR_UNDEF:
        begin
          rdata_d[0] = und_q;
          rdata_d[UND_OP_LSB +: 8] = und_op_q;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q   <= CTRL_RST;
      und_q    <= 1'b0;
      und_op_q <= 8'h00;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      und_q    <= und_d;
      und_op_q <= und_op_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

/* dv/cfs_flag_seq_properties.sv */
`timescale 1ns/1ps
module cfs_flag_seq_properties
  import cfs_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             exec_valid,
  input wire logic             exec_ready,
  input wire cfs_exec_t        exec_in,
  input wire logic             instr_end,
  input wire logic             fetch_next,
  input wire logic             undef_opcode,
  input wire logic             nmi_n,
  input wire logic             irq_take,
  input wire logic             nmi_take,
  input wire logic [CCR_W-1:0] ccr,
  input wire logic             halt_wait,
  input wire logic [15:0]      addr_force,
  input wire logic             data_bus_oe
);
  // ==========================================================
  // Instruction in flight; held so its end can be judged
  cfs_exec_t  held_d;
  cfs_exec_t  held_q;
  wire  [7:0] op = held_q.opcode;
  always_comb held_d = (exec_valid && exec_ready) ? exec_in : held_q;
  always_ff @(posedge sys_clk) held_q <= held_d;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_fetch_overlap: assert property (fetch_next == instr_end)
    else $error("fetch not with end");
  a_cycle_count: assert property (exec_valid && exec_ready &&
    exec_in.cycles == 3'd3 |-> ##1 !instr_end [*2] ##1 instr_end)
    else $error("end not after three cycles");
  a_wait_pins: assert property (halt_wait |->
    addr_force == ADDR_ONES && !data_bus_oe) else $error("wait pins");
  a_irq_mask: assert property (irq_take |=> ccr[F_I])
    else $error("mask not set");
  a_masked_wait: assert property (halt_wait && ccr[F_I] |-> !irq_take)
    else $error("masked wait left");
  a_nmi_exit: assert property (halt_wait && !nmi_n |->
    nmi_take ##1 !halt_wait && ccr[F_I]) else $error("nmi exit");
  a_rti_reload: assert property (instr_end && !irq_take &&
    op == OP_RTI |=> ccr == held_q.stacked) else $error("rti flags");
  a_tap_load: assert property (instr_end && !irq_take &&
    op == OP_TAP |=> ccr == held_q.acc_a[CCR_W-1:0])
    else $error("tap flags");
  a_mul_carry: assert property (instr_end && op == OP_MUL |=>
    ccr[F_C] == held_q.result[7]) else $error("mul carry");
  a_daa_carry: assert property (instr_end && op == OP_DAA |=>
    ccr[F_C] == ($past(ccr[F_C]) || held_q.operand[7:4] > BCD_MAX))
    else $error("daa carry");
  a_shift_ovf: assert property (instr_end && op == OP_ASLD |=>
    ccr[F_V] == (ccr[F_N] ^ ccr[F_C]) && ccr[F_N] == held_q.result[15])
    else $error("shift flags");
  a_undef_accept: assert property (undef_opcode |->
    exec_valid && exec_ready) else $error("undef outside accept");
endmodule

bind cfs_flag_seq cfs_flag_seq_properties u_props (.sys_clk, .rst_n,
  .exec_valid, .exec_ready, .exec_in, .instr_end, .fetch_next,
  .undef_opcode, .nmi_n, .irq_take, .nmi_take, .ccr, .halt_wait,
  .addr_force, .data_bus_oe);

/* dv/tb_cfs_flag_seq.sv */
`timescale 1ns/1ps
module tb_cfs_flag_seq
  import cfs_pkg::*;
;
  typedef struct packed {
    logic [7:0]  o;
    logic [15:0] r;
    logic [7:0]  d;
    logic [5:0]  e;
  } cfs_row_t;

  logic              sys_clk, rst_n, exec_valid, exec_ready, instr_end;
  logic              fetch_next, undef_opcode, irq_take, nmi_take, nmi_n;
  logic              maskable_request_one_n, maskable_request_two_n;
  logic              halt_wait, data_bus_oe, took, und;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
  logic [3:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [15:0]       addr_force;
  logic [CCR_W-1:0]  ccr;
  cfs_exec_t         exec_in;
  int                err_count, cmp_count;

  // ==========================================================
  // Rows run in order; each expects the whole flag set
  cfs_row_t rows [16] = '{
    '{8'h06, 16'h0000, 8'h2A, 6'h2A}, '{8'h3B, 16'h0000, 8'h15, 6'h15},
    '{8'h40, 16'h0080, 8'h00, 6'h17}, '{8'h40, 16'h007F, 8'h00, 6'h15},
    '{8'h4A, 16'h0000, 8'h80, 6'h17}, '{8'h4A, 16'h0000, 8'h81, 6'h15},
    '{8'h4C, 16'h0000, 8'h7F, 6'h17}, '{8'h4C, 16'h0000, 8'h80, 6'h15},
    '{8'h3D, 16'h007F, 8'h00, 6'h14}, '{8'h19, 16'h0000, 8'h20, 6'h14},
    '{8'h19, 16'h0000, 8'hA0, 6'h15}, '{8'h19, 16'h0000, 8'h20, 6'h15},
    '{8'h05, 16'h8000, 8'h00, 6'h1D}, '{8'h05, 16'h0000, 8'h00, 6'h17},
    '{8'hCC, 16'h8000, 8'h00, 6'h1F}, '{8'h0E, 16'h0000, 8'h00, 6'h0F}};

  cfs_flag_seq u_dut (.sys_clk, .rst_n, .exec_valid, .exec_ready,
    .exec_in, .instr_end, .fetch_next, .undef_opcode,
    .maskable_request_one_n, .maskable_request_two_n, .nmi_n, .irq_take,
    .nmi_take, .ccr, .halt_wait, .addr_force, .data_bus_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  // Every channel is judged at the rising edge, as the slave sees it
  task automatic ax(input logic w, input logic [3:0] a,
                    input logic [31:0] wd);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do @(posedge sys_clk); while (!(w ? s_axi_awready : s_axi_arready));
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(posedge sys_clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    rd = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask

  task automatic op(input logic [7:0] o, input logic [2:0] n,
                    input logic [7:0] d, input logic [15:0] r);
    @(posedge sys_clk);
    exec_in <= '{o, n, r, d, d, d[5:0], 6'h00, 6'h00};
    exec_valid <= 1'b1;
    do @(negedge sys_clk); while (!exec_ready);
    und = undef_opcode;
    @(posedge sys_clk);
    exec_valid <= 1'b0;
    do @(negedge sys_clk); while (!instr_end);
    took = irq_take;
    @(negedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run is under two hundred cycles; this cuts a hang short
  initial
  begin
    #20000;
    err_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {exec_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, rst_n, exec_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {maskable_request_one_n, maskable_request_two_n, nmi_n} = 3'h7;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset pins", 32'h0000_0041, 32'({ccr, halt_wait, data_bus_oe}));
    ax(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0003, rd);
    ax(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0010, rd);
    ax(1'b0, 4'hC, 32'h0000_0000);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(rs));
    ax(1'b1, 4'hC, 32'h0000_0000);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rs));
    done("reset");
    foreach (rows[i])
    begin
      op(rows[i].o, 3'd1, rows[i].d, rows[i].r);
      chk("ccr row", 32'(rows[i].e), 32'(ccr));
    end
    done("rows");
    op(OP_SEI, 3'd1, 8'h00, 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      maskable_request_one_n <= 1'(k);
      maskable_request_two_n <= 1'(1 - k);
      op(k ? OP_TAP : OP_CLI, 3'd1, 8'h00, 16'h0000);
      chk("take at clear", 32'h0000_0000, 32'(took));
      op(8'h01, k ? 3'd3 : 3'd1, 8'h00, 16'h0000);
      chk("take after next", 32'(k), 32'(took));
      if (k == 0)
      begin
        op(8'h01, 3'd1, 8'h00, 16'h0000);
        chk("take after two", 32'h0000_0001, 32'(took));
      end
    end
    @(posedge sys_clk);
    {maskable_request_one_n, maskable_request_two_n} <= 2'h3;
    done("mask delay");
    ax(1'b1, ADDR_UNDEF, 32'h0000_0001);
    op(8'h61, 3'd1, 8'h00, 16'h0000);
    chk("undef pulse 61", 32'h0000_0000, 32'(und));
    ax(1'b0, ADDR_UNDEF, 32'h0000_0000);
    chk("undef after 61", 32'h0000_0000, rd);
    op(8'h41, 3'd1, 8'h00, 16'h0000);
    chk("undef pulse 41", 32'h0000_0001, 32'(und));
    ax(1'b0, ADDR_UNDEF, 32'h0000_0000);
    chk("undef after 41", 32'h0000_4101, rd);
    done("undefined");
    op(OP_TAP, 3'd1, 8'h00, 16'h0000);
    op(OP_WAI, 3'd1, 8'h00, 16'h0000);
    chk("wait pins", 32'h0003_FFFE, 32'({halt_wait, addr_force, data_bus_oe}));
    @(posedge sys_clk);
    maskable_request_one_n <= 1'b0;
    do @(negedge sys_clk); while (!irq_take);
    @(posedge sys_clk);
    maskable_request_one_n <= 1'b1;
    @(negedge sys_clk);
    chk("irq exit", 32'h0000_0001, 32'({halt_wait, ccr[F_I]}));
    op(OP_WAI, 3'd1, 8'h00, 16'h0000);
    @(posedge sys_clk);
    maskable_request_two_n <= 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("masked wait", 32'h0000_0001, 32'(halt_wait));
    @(posedge sys_clk);
    nmi_n <= 1'b0;
    do @(negedge sys_clk); while (!nmi_take);
    @(posedge sys_clk);
    {nmi_n, maskable_request_two_n} <= 2'h3;
    @(negedge sys_clk);
    chk("nmi exit", 32'h0000_0001, 32'({halt_wait, ccr[F_I]}));
    done("wait");
    print_verdict();
  end
endmodule
